/* File: src/asm_pkg.sv */
// Purpose: shared constants for the area select and encoder speed monitor
// Assumes: 200 MHz system clock
// Notes:   byte addresses on a 32-bit register port
package asm_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ         = 200;
  localparam int SETTLE_MS       = 30;
  localparam int SETTLE_CYC      = SETTLE_MS * 1000 * CLK_MHZ;
  localparam int TEST_PULSE_US   = 300;
  localparam int TEST_PULSE_CYC  = TEST_PULSE_US * CLK_MHZ;
  localparam int TEST_PERIOD_MS  = 20;
  localparam int TEST_PERIOD_CYC = TEST_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int WINDOW_MS       = 10;
  localparam int WINDOW_CYC      = WINDOW_MS * 1000 * CLK_MHZ;
  localparam int WIN_PER_S       = 1000 / WINDOW_MS;
  // ****************************************
  // speed monitoring
  // ****************************************
  localparam int ENC_FMAX_HZ     = 100000;
  localparam int MAX_CNT_WIN     = ENC_FMAX_HZ / WIN_PER_S;
  localparam int V_SLOW_CMS      = 9;
  localparam int V_FAST_CMS      = 30;
  localparam int MIS_MID_MS      = 60000;
  localparam int MIS_FAST_MS     = 20000;
  localparam int MIS_DIR_MS      = 300;
  localparam int MIS_MID_WIN     = MIS_MID_MS / WINDOW_MS;
  localparam int MIS_FAST_WIN    = MIS_FAST_MS / WINDOW_MS;
  localparam int MIS_DIR_WIN     = MIS_DIR_MS / WINDOW_MS;
  localparam int TOL_MAX_PCT     = 45;
  localparam int PCT_FULL        = 100;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_PPCM   = 8'h04;
  localparam logic [7:0] OFF_TOL    = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_SPEED  = 8'h10;
  localparam logic [3:0] PAT_PAGE   = 4'h2;
  localparam logic [3:0] PLIM_PAGE  = 4'h3;
  localparam int CTRL_W        = 11;
  localparam int CTRL_PAIRS    = 0;
  localparam int CTRL_ENC      = 2;
  localparam int CTRL_MUTE     = 3;
  localparam int CTRL_DUAL     = 4;
  localparam int CTRL_NRNG     = 5;
  localparam logic [CTRL_W-1:0] CTRL_RST = 11'h001;
  localparam logic [15:0] PPCM_RST = 16'h0001;
  localparam logic [5:0]  SEL_RST  = 6'h07;
  localparam int PAT_AREA      = 2;
  localparam int PAT_MON       = 7;
  localparam logic [1:0] PT_STATIC  = 2'h1;
  localparam logic [1:0] PT_ENCODER = 2'h2;
  localparam int TBL_W         = 21;
  localparam int TBL_AREA      = 16;
  // ****************************************
  // error causes
  // ****************************************
  localparam int NUM_ERR    = 8;
  localparam int E_COMP     = 0;
  localparam int E_OVER     = 1;
  localparam int E_MISMATCH = 2;
  localparam int E_STATIC   = 3;
  localparam int E_TEST     = 4;
  localparam int E_CFG      = 5;
  localparam int E_UNUSED   = 6;
  localparam int E_NORANGE  = 7;
  typedef enum logic {SC_IDLE, SC_RUN} asm_scan_t;
endpackage

/* File: src/asm_range_mem.sv */
// Purpose: speed range table, one entry per range
// Assumes: software loads entries before use
// Notes:   read data registered
`timescale 1ns/1ps
`default_nettype none
module asm_range_mem #(
  parameter int DEPTH = 32,
  parameter int WIDTH = 21
) (
  // clock
  input  wire logic                     clk,
  // write side
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [WIDTH-1:0]         wdata,
  // read side
  input  wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic      [WIDTH-1:0]         rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

/* File: src/asm_monitor.sv */
// Purpose: area selection, encoder speed monitor, safety output pairs
// Assumes: selector ON = 0 on sel_norm (1 on sel_inv), detection inputs high = object present
// Notes:   error latch clears only by reset
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module asm_monitor
  import asm_pkg::*;
#(
  parameter int unsigned WINDOW_CYC_P  = WINDOW_CYC,
  parameter int unsigned SETTLE_CYC_P  = SETTLE_CYC,
  parameter int unsigned TEST_PERIOD_P = TEST_PERIOD_CYC,
  parameter int unsigned TEST_PULSE_P  = TEST_PULSE_CYC,
  parameter int unsigned RANGES        = 32
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // selector pairs
  input  wire logic [2:0]  sel_norm,
  input  wire logic [2:0]  sel_inv,
  // encoders
  input  wire logic        enc1_a,
  input  wire logic        enc1_b,
  input  wire logic        enc2_a,
  input  wire logic        enc2_b,
  // zone detection and output readback
  input  wire logic        zone1_detect,
  input  wire logic        zone2_detect,
  input  wire logic [3:0]  safety_fb,
  // safety outputs and status
  output logic             safety_out_1,
  output logic             safety_out_2,
  output logic             safety_out_3,
  output logic             safety_out_4,
  output logic      [4:0]  active_area,
  output logic             lockout
);
  // ****************************************
  // checks and state
  // ****************************************
  if (WINDOW_CYC_P < 2 || WINDOW_CYC_P >= 2**24) $error("window count out of range");
  if (SETTLE_CYC_P < 2 || SETTLE_CYC_P >= 2**24) $error("settle count out of range");
  if (TEST_PERIOD_P < 2 || TEST_PERIOD_P >= 2**24) $error("test period out of range");
  if (TEST_PULSE_P < 2 || TEST_PULSE_P >= TEST_PERIOD_P) $error("test pulse out of range");
  if (RANGES != 32) $error("range table must have 32 entries");

  typedef struct packed {
    logic [15:0]        s1;
    logic [15:0]        s2;
    logic [1:0]         a_prev;
    logic [2:0]         fill;
    logic [23:0]        win_cnt;
    logic signed [15:0] cnt1;
    logic signed [15:0] cnt2;
    logic signed [15:0] lat1;
    logic signed [15:0] lat2;
    logic               win_end;
    logic [5:0]         sel_prev;
    logic [23:0]        settle;
    logic [5:0]         sel_ok;
    logic [CTRL_W-1:0]  ctrl;
    logic [15:0]        ppcm1;
    logic [15:0]        ppcm2;
    logic [5:0]         tol;
    logic [3:0][7:0]    pat;
    logic [3:0][31:0]   plim;
    logic [15:0]        mis_cnt;
    asm_scan_t          sc_st;
    logic [5:0]         sc_idx;
    logic               sc_cmp;
    logic               sc_found;
    logic [4:0]         enc_area;
    logic [23:0]        tp_cnt;
    logic               tp_on;
    logic [3:0]         tmask;
    logic [NUM_ERR-1:0] err;
    logic [4:0]         area;
    logic [3:0]         out;
    logic [31:0]        rdata;
  } asm_state_t;

  function automatic asm_state_t rst_val();
    asm_state_t r;
    r          = '0;
    r.sel_prev = SEL_RST;
    r.sel_ok   = SEL_RST;
    r.ctrl     = CTRL_RST;
    r.ppcm1    = PPCM_RST;
    r.ppcm2    = PPCM_RST;
    r.sc_st    = SC_IDLE;
    return r;
  endfunction
  localparam asm_state_t ST_RST = rst_val();

  // speed * ppcm comparison without division: sign of cnt*rate - v*ppcm
  function automatic logic signed [47:0] spd_diff(input logic signed [15:0] cnt,
                                                  input logic [15:0] ppcm,
                                                  input logic signed [15:0] v);
    logic signed [47:0] l;
    logic signed [47:0] r;
    l = $signed({{32{cnt[15]}}, cnt}) * $signed(48'(WIN_PER_S));
    r = $signed({{32{v[15]}}, v}) * $signed({32'h00000000, ppcm});
    return l - r;
  endfunction

  asm_state_t         q;
  asm_state_t         n;
  logic               rst_s1_q;
  logic               rst_ok_q;
  logic [TBL_W-1:0]   tbl_rdata;
  logic [5:0]         sel;
  logic               e1a, e1b, e2a, e2b, z1, z2;
  logic [3:0]         fb;
  logic               enc;
  logic [1:0]         pairs;
  logic [2:0]         sel_mask;
  logic [2:0]         sel_idx;
  logic               comp_bad;
  logic [7:0]         pat_sel;
  logic [1:0]         pat_type;
  logic [5:0]         nrng;
  logic [15:0]        m1, m2;
  logic [31:0]        s1x, s2x;
  logic               pick1;
  logic signed [15:0] vcnt;
  logic [15:0]        vppcm;
  logic [15:0]        vmag;
  logic               slow, fast, over, dirdis, mism, mis_hit, st_out, hit;
  logic signed [47:0] xdiff, xabs;
  logic [15:0]        mis_lim;

  // ****************************************
  // reset release
  // ****************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_q <= 1'b0;
      rst_ok_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_ok_q <= rst_s1_q;
    end
  end

  // ****************************************
  // derived terms
  // ****************************************
  assign sel = q.s2[5:0];
  assign e1a = q.s2[6];
  assign e1b = q.s2[7];
  assign e2a = q.s2[8];
  assign e2b = q.s2[9];
  assign z1  = q.s2[10];
  assign z2  = q.s2[11];
  assign fb  = q.s2[15:12];
  assign enc      = q.ctrl[CTRL_ENC];
  assign pairs    = enc ? 2'h2 : (q.ctrl[CTRL_PAIRS+:2] == 2'h0 ? 2'h1 : q.ctrl[CTRL_PAIRS+:2]);
  assign sel_mask = (pairs == 2'h1) ? 3'h1 : (pairs == 2'h2) ? 3'h3 : 3'h7;
  assign sel_idx  = ~q.sel_ok[2:0] & sel_mask;
  assign comp_bad = |((q.sel_ok[2:0] ~^ q.sel_ok[5:3]) & sel_mask);
  assign pat_sel  = q.pat[sel_idx[1:0]];
  assign pat_type = pat_sel[1:0];
  assign nrng     = (q.ctrl[CTRL_NRNG+:6] > 6'h20) ? 6'h20 : q.ctrl[CTRL_NRNG+:6];
  assign m1    = q.lat1[15] ? 16'(-q.lat1) : q.lat1;
  assign m2    = q.lat2[15] ? 16'(-q.lat2) : q.lat2;
  assign s1x   = {16'h0000, m1} * {16'h0000, q.ppcm2};
  assign s2x   = {16'h0000, m2} * {16'h0000, q.ppcm1};
  assign pick1 = s1x >= s2x;
  assign vcnt  = pick1 ? q.lat1 : q.lat2;
  assign vppcm = pick1 ? q.ppcm1 : q.ppcm2;
  assign vmag  = pick1 ? m1 : m2;
  assign slow  = spd_diff(vmag, vppcm, 16'(V_SLOW_CMS)) <= 0;
  assign fast  = spd_diff(vmag, vppcm, 16'(V_FAST_CMS)) >= 0;
  assign over  = (m1 > 16'(MAX_CNT_WIN)) || (m2 > 16'(MAX_CNT_WIN));
  assign dirdis = (q.lat1 != 16'sh0000) && (q.lat2 != 16'sh0000) && (q.lat1[15] != q.lat2[15]) && !slow;
  assign xdiff = $signed({{32{q.lat1[15]}}, q.lat1}) * $signed({32'h00000000, q.ppcm2})
               - $signed({{32{q.lat2[15]}}, q.lat2}) * $signed({32'h00000000, q.ppcm1});
  assign xabs  = xdiff[47] ? -xdiff : xdiff;
  assign mism  = xabs * 48'(PCT_FULL) > $signed({42'h0, q.tol} * {16'h0000, (pick1 ? s1x : s2x)});
  assign mis_hit = dirdis || (mism && !slow);
  assign mis_lim = dirdis ? 16'(MIS_DIR_WIN) : fast ? 16'(MIS_FAST_WIN) : 16'(MIS_MID_WIN);
  assign st_out = (spd_diff(vcnt, vppcm, $signed(q.plim[sel_idx[1:0]][15:0])) < 0)
               || (spd_diff(vcnt, vppcm, $signed(q.plim[sel_idx[1:0]][31:16])) > 0);
  assign hit   = spd_diff(vcnt, vppcm, $signed(tbl_rdata[15:0])) <= 0;

  asm_range_mem #(.DEPTH(RANGES), .WIDTH(TBL_W)) u_tbl (
    .clk   (clk),
    .we    (reg_wr && reg_addr[7]),
    .waddr (reg_addr[6:2]),
    .wdata (reg_wdata[TBL_W-1:0]),
    .raddr (q.sc_idx[4:0]),
    .rdata (tbl_rdata)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [NUM_ERR-1:0] ne;
    logic signed [15:0] inc1;
    logic signed [15:0] inc2;
    logic               on1;
    logic               on2;
    ne   = '0;
    inc1 = 16'sh0000;
    inc2 = 16'sh0000;
    on1  = 1'b0;
    on2  = 1'b0;
    n    = q;
    n.s1 = {safety_fb, zone2_detect, zone1_detect, enc2_b, enc2_a, enc1_b, enc1_a, sel_inv, sel_norm};
    n.s2 = q.s1;
    n.a_prev = {e2a, e1a};
    // no edges counted until synchroniser and edge flop hold real pin levels
    n.fill   = {q.fill[1:0], 1'b1};
    if (e1a && !q.a_prev[0] && q.fill[2]) begin
      inc1 = e1b ? 16'sh0001 : 16'shffff;
    end
    if (e2a && !q.a_prev[1] && q.fill[2]) begin
      inc2 = e2b ? 16'sh0001 : 16'shffff;
    end
    n.cnt1    = q.cnt1 + inc1;
    n.cnt2    = q.cnt2 + inc2;
    n.win_end = 1'b0;
    if (q.win_cnt == 24'(WINDOW_CYC_P - 1)) begin
      n.win_cnt = '0;
      n.lat1    = n.cnt1;
      n.lat2    = n.cnt2;
      n.cnt1    = 16'sh0000;
      n.cnt2    = 16'sh0000;
      n.win_end = 1'b1;
    end else begin
      n.win_cnt = q.win_cnt + 24'h000001;
    end
    // selector settling
    n.sel_prev = sel;
    if (sel != q.sel_prev) begin
      n.settle = '0;
    end else if (q.settle != 24'(SETTLE_CYC_P - 1)) begin
      n.settle = q.settle + 24'h000001;
    end else begin
      n.sel_ok = sel;
    end
    ne[E_COMP] = comp_bad;
    ne[E_CFG]  = enc && (q.ctrl[CTRL_MUTE] || q.ctrl[CTRL_DUAL]);
    // speed checks once per window
    if (q.win_end) begin
      ne[E_OVER] = over;
      if (enc) begin
        if (mis_hit) begin
          n.mis_cnt = (q.mis_cnt == 16'hffff) ? q.mis_cnt : q.mis_cnt + 16'h0001;
          ne[E_MISMATCH] = (q.mis_cnt + 16'h0001) >= mis_lim;
        end else begin
          n.mis_cnt = '0;
        end
        ne[E_STATIC] = (pat_type == PT_STATIC) && pat_sel[PAT_MON] && st_out;
      end
    end
    // area selection
    if (!enc) begin
      n.area = {2'h0, sel_idx};
    end else if (pat_type == PT_STATIC) begin
      n.area = pat_sel[PAT_AREA+:5];
    end else if (pat_type == PT_ENCODER) begin
      n.area = q.enc_area;
    end else begin
      ne[E_UNUSED] = 1'b1;
    end
    // speed range scan, first matching range wins
    n.sc_cmp = 1'b0;
    case (q.sc_st)
      SC_IDLE: begin
        if (q.win_end && enc) begin
          n.sc_idx   = '0;
          n.sc_found = 1'b0;
          if (nrng != 6'h00) begin
            n.sc_st = SC_RUN;
          end else begin
            ne[E_NORANGE] = (pat_type == PT_ENCODER);
          end
        end
      end
      SC_RUN: begin
        n.sc_cmp = 1'b1;
        n.sc_idx = q.sc_idx + 6'h01;
        if (q.sc_idx == nrng - 6'h01) begin
          n.sc_st = SC_IDLE;
        end
      end
      default: begin
        n.sc_st = SC_IDLE;
      end
    endcase
    if (q.sc_cmp && !q.sc_found && hit) begin
      n.enc_area = tbl_rdata[TBL_AREA+:5];
      n.sc_found = 1'b1;
    end
    if (q.sc_cmp && q.sc_st == SC_IDLE && !q.sc_found && !hit) begin
      ne[E_NORANGE] = (pat_type == PT_ENCODER);
    end
    // periodic output test
    if (q.tp_on) begin
      if (q.tp_cnt == 24'(TEST_PULSE_P - 1)) begin
        n.tp_on    = 1'b0;
        n.tp_cnt   = '0;
        ne[E_TEST] = |(fb & q.tmask);
      end else begin
        n.tp_cnt = q.tp_cnt + 24'h000001;
      end
    end else if (q.tp_cnt == 24'(TEST_PERIOD_P - 1)) begin
      n.tp_on  = 1'b1;
      n.tp_cnt = '0;
      n.tmask  = q.out;
    end else begin
      n.tp_cnt = q.tp_cnt + 24'h000001;
    end
    n.err = q.err | ne;
    on1   = ~|n.err && !z1 && !n.tp_on;
    on2   = ~|n.err && !z2 && !n.tp_on && q.ctrl[CTRL_DUAL];
    n.out = {on2, on2, on1, on1};
    // register port
    if (reg_wr) begin
      case (reg_addr)
        OFF_CTRL: n.ctrl = reg_wdata[CTRL_W-1:0];
        OFF_PPCM: begin
          n.ppcm1 = reg_wdata[15:0];
          n.ppcm2 = reg_wdata[31:16];
        end
        OFF_TOL:  n.tol = (reg_wdata > 32'(TOL_MAX_PCT)) ? 6'(TOL_MAX_PCT) : reg_wdata[5:0];
        default: begin
          if (reg_addr[7:4] == PAT_PAGE) begin
            n.pat[reg_addr[3:2]] = reg_wdata[7:0];
          end else if (reg_addr[7:4] == PLIM_PAGE) begin
            n.plim[reg_addr[3:2]] = reg_wdata;
          end
        end
      endcase
    end
    n.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        OFF_CTRL:   n.rdata = {21'h000000, q.ctrl};
        OFF_PPCM:   n.rdata = {q.ppcm2, q.ppcm1};
        OFF_TOL:    n.rdata = {26'h0000000, q.tol};
        OFF_STATUS: n.rdata = {19'h00000, q.err, q.area};
        OFF_SPEED:  n.rdata = {q.lat2, q.lat1};
        default: begin
          if (reg_addr[7:4] == PAT_PAGE) begin
            n.rdata = {24'h000000, q.pat[reg_addr[3:2]]};
          end else if (reg_addr[7:4] == PLIM_PAGE) begin
            n.rdata = q.plim[reg_addr[3:2]];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_ok_q) begin
    if (!rst_ok_q) begin
      q <= ST_RST;
    end else begin
      q <= n;
    end
  end

  assign reg_rdata    = q.rdata;
  assign safety_out_1 = q.out[0];
  assign safety_out_2 = q.out[1];
  assign safety_out_3 = q.out[2];
  assign safety_out_4 = q.out[3];
  assign active_area  = q.area;
  assign lockout      = |q.err;

  // ****************************************
  // assertions
  // ****************************************
  logic [23:0] tp_len_q;
  always_ff @(posedge clk or negedge rst_ok_q) begin
    if (!rst_ok_q) begin
      tp_len_q <= '0;
    end else begin
      tp_len_q <= q.tp_on ? tp_len_q + 24'h000001 : 24'h000000;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_ok_q);

  a_pair_equal:      assert property (q.out[0] == q.out[1] && q.out[2] == q.out[3])
    else $error("safety pair outputs differ");
  a_lock_off:        assert property ((|q.err) |-> q.out == 4'h0)
    else $error("output on while locked");
  a_lock_sticky:     assert property ((|q.err) |=> (|q.err) [*8])
    else $error("lock released without reset");
  a_zone_off:        assert property (z1 |=> !q.out[0])
    else $error("output on with detection");
  a_test_forces:     assert property (q.tp_on |-> !q.out[0] && !q.out[2])
    else $error("output on during test pulse");
  a_pulse_len:       assert property ($fell(q.tp_on) |-> tp_len_q == 24'(TEST_PULSE_P))
    else $error("test pulse length wrong");
  a_cfg_reject:      assert property (enc && q.ctrl[CTRL_MUTE] |=> q.err[E_CFG] && !q.out[0])
    else $error("bad configuration not rejected");
  a_comp_error:      assert property (comp_bad |=> q.err[E_COMP])
    else $error("selector pair fault missed");
  a_area_decode:     assert property (!enc && !reg_wr |=> q.area == {2'h0, $past(sel_idx)})
    else $error("area decode wrong");
  a_dir_forward:     assert property (q.fill[2] && e1a && !q.a_prev[0] && e1b && !n.win_end
                                      |=> q.cnt1 == $past(q.cnt1) + 16'sh0001)
    else $error("forward edge not counted up");
  a_dir_backward:    assert property (q.fill[2] && e1a && !q.a_prev[0] && !e1b && !n.win_end
                                      |=> q.cnt1 == $past(q.cnt1) - 16'sh0001)
    else $error("backward edge not counted down");
  a_settle_hold:     assert property (sel != q.sel_prev |=> q.sel_ok == $past(q.sel_ok))
    else $error("selector taken before settling");
  a_mismatch_trip:   assert property (q.win_end && enc && mis_hit && (q.mis_cnt + 16'h0001 >= mis_lim)
                                      |=> q.err[E_MISMATCH] ##1 q.out == 4'h0)
    else $error("mismatch did not trip");

  c_lockout:     cover property ($rose(|q.err));
  c_test_pulse:  cover property ($fell(q.tp_on) && q.tmask != 4'h0);
  c_range_found: cover property (q.sc_cmp && !q.sc_found && hit);
  c_static_area: cover property (enc && pat_type == PT_STATIC ##1 q.area == $past(pat_sel[PAT_AREA+:5]));
endmodule
`default_nettype wire

/* File: testbench/asm_far_side.sv */
// Purpose: two quadrature encoders and relay readback
// Assumes: one clock, encoder period 20 cycles
// Notes:   stuck holds readback high like a welded relay
`timescale 1ns/1ps
`default_nettype none
module asm_far_side (
  // control
  input  wire logic       clk,
  input  wire logic       en,
  input  wire logic       dir1,
  input  wire logic       dir2,
  input  wire logic       stuck,
  // relay coils
  input  wire logic [3:0] outs,
  // encoder lines and readback
  output logic            enc1_a,
  output logic            enc1_b,
  output logic            enc2_a,
  output logic            enc2_b,
  output logic      [3:0] fb
);
  int ph = 0;
  // lines stand still while the vehicle stops
  always @(posedge clk) if (en) ph <= (ph + 1) % 20;
  // b high at a rise means forward, two separate encoders
  assign enc1_a = ph < 10;
  assign enc1_b = ((ph + (dir1 ? 5 : 15)) % 20) < 10;
  assign enc2_a = ph < 10;
  assign enc2_b = ((ph + (dir2 ? 5 : 15)) % 20) < 10;
  // readback follows the coils unless stuck
  assign fb = stuck ? 4'hf : outs;
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
// Purpose: self-checking bench for the area monitor
// Assumes: shortened window, settle and test periods
// Notes:   far side model drives encoders and readback
`timescale 1ns/1ps
`default_nettype none
module tb;
  import asm_pkg::*;
  localparam int WIN = 200;
  localparam int LIM0 = 500;
  logic        clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, z1 = 0, z2 = 0;
  logic        en = 0, d1 = 1, d2 = 1, stuck = 0, o1, o2, o3, o4, lockout;
  logic        e1a, e1b, e2a, e2b;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rv;
  logic [2:0]  sel_norm = 3'h7, sel_inv = 3'h0;
  logic [3:0]  fb;
  logic [4:0]  active_area;
  int          mismatches = 0, num_checks = 0, seed = 21297, base, v, exp_cnt;
  asm_monitor #(.WINDOW_CYC_P(WIN), .SETTLE_CYC_P(16), .TEST_PERIOD_P(2000), .TEST_PULSE_P(60)) u_asm_monitor (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sel_norm(sel_norm), .sel_inv(sel_inv), .enc1_a(e1a), .enc1_b(e1b), .enc2_a(e2a),
    .enc2_b(e2b), .zone1_detect(z1), .zone2_detect(z2), .safety_fb(fb), .safety_out_1(o1),
    .safety_out_2(o2), .safety_out_3(o3), .safety_out_4(o4), .active_area(active_area), .lockout(lockout));
  asm_far_side u_asm_far_side (.clk(clk), .en(en), .dir1(d1), .dir2(d2), .stuck(stuck),
    .outs({o4, o3, o2, o1}), .enc1_a(e1a), .enc1_b(e1b), .enc2_a(e2a), .enc2_b(e2b), .fb(fb));
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic acc(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= w;
    reg_rd    <= !w;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b0;
    @(posedge clk);
    rv = reg_rdata;
  endtask
  task automatic wait_lock(int n);
    for (int i = 0; i < n && lockout !== 1'b1; i++) @(posedge clk);
  endtask
  task automatic do_reset();
    rstn <= 1'b0;
    repeat (12) @(posedge clk);
    chk(32'({o1, o2, lockout}), 32'h0);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial forever #2.5 clk = ~clk;
  initial begin
    #200000;
    mismatches++;
    finish_test();
  end
  initial begin
    do_reset();
    for (int np = 1; np <= 3; np++) begin
      acc(1'b1, OFF_CTRL, 32'(np));
      base = $random(seed);
      for (int i = 0; i < 8; i++) begin
        v = (base + i) & 7;
        sel_norm <= ~3'(v);
        sel_inv  <= 3'(v);
        repeat (30) @(posedge clk);
        chk(32'(active_area), 32'(v & ((1 << np) - 1)));
        chk(32'(o1), 32'(o2));
      end
    end
    $display("selector decode done");
    sel_norm <= 3'h7;
    sel_inv  <= 3'h0;
    repeat (30) @(posedge clk);
    acc(1'b1, OFF_PPCM, 32'h00010001);
    acc(1'b1, OFF_TOL, 32'h3c);
    acc(1'b0, OFF_TOL, 32'h0);
    chk(rv, 32'(TOL_MAX_PCT));
    acc(1'b1, {PAT_PAGE, 4'h0}, 32'(PT_ENCODER));
    acc(1'b1, 8'h80, {11'h000, 5'h03, 16'(LIM0)});
    acc(1'b1, 8'h84, {11'h000, 5'h04, 16'(4 * LIM0)});
    acc(1'b1, OFF_CTRL, 32'h44);
    en <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      d1 <= k == 0;
      d2 <= k == 0;
      repeat (3 * WIN) @(posedge clk);
      acc(1'b0, OFF_SPEED, 32'h0);
      exp_cnt = k == 0 ? WIN / 20 : -(WIN / 20);
      chk(rv, {16'(exp_cnt), 16'(exp_cnt)});
      chk(32'(active_area), (exp_cnt * WIN_PER_S <= LIM0) ? 32'h3 : 32'h4);
    end
    d1 <= 1'b1;
    repeat (25 * WIN) @(posedge clk);
    chk(32'(lockout), 32'h0);
    wait_lock(15 * WIN);
    en <= 1'b0;
    repeat (2 * WIN) @(posedge clk);
    chk(32'({lockout, o1, o2}), 32'h4);
    $display("encoder direction done");
    do_reset();
    chk(32'({o1, o2}), 32'h3);
    acc(1'b1, OFF_CTRL, 32'h11);
    repeat (2) @(posedge clk);
    chk(32'({o1, o2, o3, o4}), 32'hf);
    z2 <= 1'b1;
    repeat (4) @(posedge clk);
    chk(32'({o1, o2, o3, o4}), 32'hc);
    z1 <= 1'b1;
    repeat (4) @(posedge clk);
    chk(32'({o1, o2}), 32'h0);
    z1 <= 1'b0;
    z2 <= 1'b0;
    stuck <= 1'b1;
    wait_lock(2 * 2000 + 200);
    chk(32'({lockout, o1, o2}), 32'h4);
    stuck <= 1'b0;
    $display("safety outputs done");
    do_reset();
    sel_inv <= sel_norm;
    wait_lock(40);
    chk(32'({lockout, o1}), 32'h2);
    sel_inv <= ~sel_norm;
    repeat (40) @(posedge clk);
    chk(32'({lockout, o1}), 32'h2);
    acc(1'b1, OFF_CTRL, 32'h0c);
    acc(1'b0, OFF_STATUS, 32'h0);
    chk(32'(rv[5 + E_CFG]), 32'h1);
    $display("selector error done");
    finish_test();
  end
endmodule
`default_nettype wire
